// file: src/sclc_top.sv
// top: control, counter, id bus and select scan registers with condition output
`timescale 1ns/1ps
module sclc_top
   import sclc_pkg::*;
(
   input  wire logic              ref_clk,                     // system clock
   input  wire logic              nrst,                        // sync reset, active low
   input  wire sclc_tap_e         tap_state,                   // tap controller state
   input  wire sclc_instr_e       instr,                       // decoded current instruction
   input  wire logic              tck_rise,                    // test clock rising edge enable
   input  wire logic              tck_fall,                    // test clock falling edge enable
   input  wire logic              tdi,                         // serial test data in
   input  wire logic [IDB_W-1:0]  id_bus,                      // identification bus inputs
   input  wire logic              condition_input,             // condition input pin
   input  wire logic              instruction_parity_error_n,  // parity error, active low
   output logic                   tdo,                         // serial test data out
   output logic                   tdo_oe_n,                    // tdo drive enable, low drives
   output logic                   condition_output,            // condition output level
   output logic                   condition_output_oe_n,       // condition output enable, low drives
   output logic                   downstream_test_clock_oe_n,  // downstream clock enable, low drives
   output logic [NPATH-1:0]       downstream_mode_select_oe_n, // downstream mode enables, low drives
   output logic [NPATH-1:0]       downstream_data_out_oe_n,    // downstream data enables, low drives
   output logic [CNT_W-1:0]       count_value,                 // live counter value
   output logic [CTL_W-1:0]       scan_control_register        // decoded control settings
);

   ////////////////////////////////////////////////////////////////////////////
   // tap strobes

   logic trst;
   logic cap_str;
   logic sh_str;
   logic upd_str;

   assign trst    = (tap_state == TAP_RESET);
   assign cap_str = tck_rise && (tap_state == TAP_CAP_DR);
   assign sh_str  = tck_rise && (tap_state == TAP_SHIFT_DR);
   assign upd_str = tck_fall && (tap_state == TAP_UPD_DR);

   ////////////////////////////////////////////////////////////////////////////
   // scan registers

   logic [CTL_W-1:0] ctl_sh;
   logic [CNT_W-1:0] cnt_sh;
   logic [IDB_W-1:0] idb_sh;
   logic [SEL_W-1:0] sel_sh;
   logic             ctl_sdo;
   logic             cnt_sdo;
   logic             idb_sdo;
   logic             sel_sdo;
   logic [CNT_W-1:0] counter_q;
   logic [CNT_W-1:0] counter_d;
   logic [CNT_W-1:0] preload_q;
   logic [CNT_W-1:0] preload_d;
   logic             is_cnt;

   assign is_cnt = (instr == INS_SCAN_CNT) || (instr == INS_READ_CNT);

   // control path
   // ten bit control chain, never captured, cleared by test reset
   sclc_shift_reg #(.W(CTL_W), .RST_VAL(CTL_RST), .CLR_ON_TRST(1'b1)) u_ctl (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .trst     (trst),
      .cap_en   (1'b0),
      .cap_val  (CTL_RST),
      .shift_en (sh_str && (instr == INS_SCAN_CTL)),
      .sdi      (tdi),
      .q        (ctl_sh),
      .sdo      (ctl_sdo)
   );

   // counter capture
   // live count or earlier preload picked by instruction
   sclc_shift_reg #(.W(CNT_W), .RST_VAL(CNT_RST), .CLR_ON_TRST(1'b0)) u_cnt (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .trst     (trst),
      .cap_en   (cap_str && is_cnt),
      .cap_val  ((instr == INS_READ_CNT) ? preload_q : counter_q),
      .shift_en (sh_str && is_cnt),
      .sdi      (tdi),
      .q        (cnt_sh),
      .sdo      (cnt_sdo)
   );

   // id bus sampling
   // only the scan form samples the bus, read form just shifts
   sclc_shift_reg #(.W(IDB_W), .RST_VAL('0), .CLR_ON_TRST(1'b0)) u_idb (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .trst     (trst),
      .cap_en   (cap_str && (instr == INS_SCAN_IDB)),
      .cap_val  (id_bus),
      .shift_en (sh_str && ((instr == INS_SCAN_IDB) || (instr == INS_READ_IDB))),
      .sdi      (tdi),
      .q        (idb_sh),
      .sdo      (idb_sdo)
   );

   // select chain
   // shifted only, never captured
   sclc_shift_reg #(.W(SEL_W), .RST_VAL(SEL_RST), .CLR_ON_TRST(1'b1)) u_sel (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .trst     (trst),
      .cap_en   (1'b0),
      .cap_val  (SEL_RST),
      .shift_en (sh_str && (instr == INS_SCAN_SEL)),
      .sdi      (tdi),
      .q        (sel_sh),
      .sdo      (sel_sdo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control settings, counter and condition logic

   logic [CTL_W-1:0] ctl_q;
   logic [CTL_W-1:0] ctl_d;
   logic             cin_act_q;
   logic             cin_act_d;
   logic             pause_q;
   logic             pause_d;
   logic             cin_act;
   logic             down;
   logic             hold_zero;
   logic             term_n;
   logic             cnt_step;

   assign down    = ctl_q[CTL_DOWN];
   assign cin_act = (condition_input == ctl_q[CTL_IPOL]);
   assign hold_zero = down && ctl_q[CTL_LATCH] && (counter_q == CNT_ZERO);
   assign term_n = !((down && (counter_q == CNT_ZERO)) || (!down && (counter_q == CNT_ONES)));
   assign cnt_step = (instr == INS_COUNT) && (tap_state == TAP_IDLE) && cin_act && !cin_act_q && !hold_zero;

   // next values of settings, counter, preload and pause flag
   always_comb begin
      ctl_d     = ctl_q;
      counter_d = counter_q;
      preload_d = preload_q;
      cin_act_d = cin_act;
      pause_d   = pause_q;
      if (upd_str && (instr == INS_SCAN_CTL)) begin
         ctl_d = ctl_sh;
      end
      if (upd_str && is_cnt) begin
         counter_d = cnt_sh;
         preload_d = cnt_sh;
      end else if (cnt_step) begin
         counter_d = down ? (counter_q - CNT_STEP) : (counter_q + CNT_STEP);
      end
      if (tck_fall) begin
         pause_d = (tap_state == TAP_PAUSE_IR);
      end
      if (!nrst || trst) begin
         ctl_d   = CTL_RST;
         pause_d = 1'b0;
      end
      if (!nrst) begin
         counter_d = CNT_RST;
         preload_d = CNT_RST;
      end
   end

   // register only
   always_ff @(posedge ref_clk) begin
      ctl_q     <= ctl_d;
      counter_q <= counter_d;
      preload_q <= preload_d;
      cin_act_q <= cin_act_d;
      pause_q   <= pause_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // output flops

   logic [1:0]       src;
   logic             co_active;
   logic             co_level;
   logic             co_q;
   logic             co_d;
   logic             co_oe_n_q;
   logic             co_oe_n_d;
   logic             tdo_q;
   logic             tdo_d;
   logic             tdo_oe_n_q;
   logic             tdo_oe_n_d;
   logic             dck_oe_n_q;
   logic [NPATH-1:0] dms_oe_n_q;
   logic [NPATH-1:0] dms_oe_n_d;
   logic [NPATH-1:0] ddo_oe_n_q;
   logic [NPATH-1:0] ddo_oe_n_d;
   logic             shifting;

   assign src      = {ctl_q[CTL_SRC_HI], ctl_q[CTL_SRC_LO]};
   assign shifting = (tap_state == TAP_SHIFT_DR) || (tap_state == TAP_SHIFT_IR);

   // condition output source, polarity and drive
   always_comb begin
      co_active = 1'b0;
      unique case (src)
         SRC_IDLE: co_active = 1'b0;
         SRC_PERR: co_active = pause_q && !instruction_parity_error_n && !ctl_q[CTL_PMASK];
         SRC_TERM: co_active = !term_n;
         SRC_CIN:  co_active = cin_act;
      endcase
      co_level = ctl_q[CTL_OPOL] ? co_active : !co_active;
      co_d      = 1'b1;
      co_oe_n_d = 1'b1;
      if (ctl_q[CTL_OEN]) begin
         co_d      = co_level;
         co_oe_n_d = ctl_q[CTL_TRISTATE] ? 1'b0 : co_level;
      end
   end

   // serial output and downstream enables
   always_comb begin
      tdo_d      = tdo_q;
      tdo_oe_n_d = tdo_oe_n_q;
      if (tck_fall) begin
         tdo_oe_n_d = (tap_state != TAP_SHIFT_DR);
         unique case (instr)
            INS_SCAN_CTL:                tdo_d = ctl_sdo;
            INS_SCAN_CNT, INS_READ_CNT:  tdo_d = cnt_sdo;
            INS_SCAN_IDB, INS_READ_IDB:  tdo_d = idb_sdo;
            INS_SCAN_SEL:                tdo_d = sel_sdo;
            INS_OTHER, INS_COUNT:        tdo_d = 1'b0;
         endcase
      end
      for (int i = 0; i < NPATH; i++) begin
         dms_oe_n_d[i] = ctl_d[CTL_DDIS];
         ddo_oe_n_d[i] = ctl_d[CTL_DDIS] || !sel_sh[2*i+1] || !shifting;
      end
      if (!nrst) begin
         tdo_d      = 1'b0;
         tdo_oe_n_d = 1'b1;
      end
   end

   // register only
   always_ff @(posedge ref_clk) begin
      co_q       <= co_d;
      co_oe_n_q  <= co_oe_n_d;
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
      dck_oe_n_q <= ctl_d[CTL_DDIS];
      dms_oe_n_q <= dms_oe_n_d;
      ddo_oe_n_q <= ddo_oe_n_d;
   end

   assign tdo                         = tdo_q;
   assign tdo_oe_n                    = tdo_oe_n_q;
   assign condition_output            = co_q;
   assign condition_output_oe_n       = co_oe_n_q;
   assign downstream_test_clock_oe_n  = dck_oe_n_q;
   assign downstream_mode_select_oe_n = dms_oe_n_q;
   assign downstream_data_out_oe_n    = ddo_oe_n_q;
   assign count_value                 = counter_q;
   assign scan_control_register       = ctl_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_cnt_cap;
      cap_str && (instr == INS_SCAN_CNT);
   endsequence

   sequence s_cnt_upd;
      upd_str && is_cnt;
   endsequence

   property p_ctl_nocap;
      cap_str && (instr == INS_SCAN_CTL) && !trst |=> $stable(ctl_sh);
   endproperty
   a_ctl_nocap: assert property (p_ctl_nocap) else $error("control chain changed at capture");

   property p_cnt_cap;
      s_cnt_cap |=> (cnt_sh == $past(counter_q));
   endproperty
   a_cnt_cap: assert property (p_cnt_cap) else $error("counter capture wrong");

   property p_cnt_read;
      cap_str && (instr == INS_READ_CNT) |=> (cnt_sh == $past(preload_q));
   endproperty
   a_cnt_read: assert property (p_cnt_read) else $error("counter read capture wrong");

   property p_cnt_upd;
      s_cnt_upd ##0 (!trst) |=> (counter_q == $past(cnt_sh)) && (preload_q == $past(cnt_sh));
   endproperty
   a_cnt_upd: assert property (p_cnt_upd) else $error("counter preload wrong");

   property p_idb_cap;
      cap_str && (instr == INS_SCAN_IDB) |=> (idb_sh == $past(id_bus));
   endproperty
   a_idb_cap: assert property (p_idb_cap) else $error("id bus not sampled");

   property p_idb_read;
      cap_str && (instr == INS_READ_IDB) |=> $stable(idb_sh);
   endproperty
   a_idb_read: assert property (p_idb_read) else $error("id bus read captured");

   property p_sel_nocap;
      cap_str && (instr == INS_SCAN_SEL) && !trst |=> $stable(sel_sh);
   endproperty
   a_sel_nocap: assert property (p_sel_nocap) else $error("select chain loaded");

   property p_trst;
      trst |=> (ctl_q == CTL_RST) && (ctl_sh == CTL_RST);
   endproperty
   a_trst: assert property (p_trst) else $error("test reset left control bits");

   property p_ctl_hold;
      !(upd_str && (instr == INS_SCAN_CTL)) && !trst |=> $stable(ctl_q);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("settings moved outside update");

   property p_latch;
      hold_zero && !(upd_str && is_cnt) |=> (counter_q == CNT_ZERO);
   endproperty
   a_latch: assert property (p_latch) else $error("counter left zero while latched");

   property p_idle_only;
      (tap_state != TAP_IDLE) && !(upd_str && is_cnt) |=> $stable(counter_q);
   endproperty
   a_idle_only: assert property (p_idle_only) else $error("counter moved outside idle");

   property p_co_off;
      !ctl_q[CTL_OEN] |=> co_oe_n_q && co_q;
   endproperty
   a_co_off: assert property (p_co_off) else $error("disabled condition output driven");

   property p_dclk;
      (dck_oe_n_q == ctl_q[CTL_DDIS]) && (dms_oe_n_q == {NPATH{ctl_q[CTL_DDIS]}});
   endproperty
   a_dclk: assert property (p_dclk) else $error("downstream clock gate wrong");

endmodule

// file: src/sclc_pkg.sv
// package: constants and types for the scan linker control and counter block
package sclc_pkg;

   // register widths
   localparam int unsigned CTL_W = 10;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned IDB_W = 4;
   localparam int unsigned SEL_W = 8;
   localparam int unsigned NPATH = 4;

   // control register bit positions
   localparam int unsigned CTL_DOWN     = 9;
   localparam int unsigned CTL_LATCH    = 8;
   localparam int unsigned CTL_OPOL     = 7;
   localparam int unsigned CTL_SRC_HI   = 6;
   localparam int unsigned CTL_SRC_LO   = 5;
   localparam int unsigned CTL_PMASK    = 4;
   localparam int unsigned CTL_TRISTATE = 3;
   localparam int unsigned CTL_OEN      = 2;
   localparam int unsigned CTL_IPOL     = 1;
   localparam int unsigned CTL_DDIS     = 0;

   // reset values and counter terminal values
   localparam logic [CTL_W-1:0] CTL_RST  = 10'h000;
   localparam logic [SEL_W-1:0] SEL_RST  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONES = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;

   // condition output source codes (bits 6 and 5)
   localparam logic [1:0] SRC_IDLE = 2'h0;
   localparam logic [1:0] SRC_PERR = 2'h1;
   localparam logic [1:0] SRC_TERM = 2'h2;
   localparam logic [1:0] SRC_CIN  = 2'h3;

   // test access port controller states
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } sclc_tap_e;

   // decoded instructions that matter to this block
   typedef enum logic [2:0] {
      INS_OTHER, INS_COUNT, INS_SCAN_CTL, INS_SCAN_CNT, INS_READ_CNT,
      INS_SCAN_IDB, INS_READ_IDB, INS_SCAN_SEL
   } sclc_instr_e;

endpackage

// file: src/sclc_shift_reg.sv
// serial shift register with optional parallel capture and test reset
`timescale 1ns/1ps
module sclc_shift_reg
   import sclc_pkg::*;
#(
   parameter int unsigned W = 8,
   parameter logic [W-1:0] RST_VAL = '0,
   parameter bit          CLR_ON_TRST = 1'b1
) (
   input  wire logic         ref_clk,  // system clock
   input  wire logic         nrst,     // sync reset, active low
   input  wire logic         trst,     // test logic reset level
   input  wire logic         cap_en,   // parallel capture strobe
   input  wire logic [W-1:0] cap_val,  // parallel capture value
   input  wire logic         shift_en, // shift strobe
   input  wire logic         sdi,      // serial in
   output logic      [W-1:0] q,        // register contents
   output logic              sdo       // serial out
);

   logic [W-1:0] q_q;
   logic [W-1:0] q_d;

   // next value: reset, capture, or shift toward bit 0
   always_comb begin
      q_d = q_q;
      if (!nrst || (trst && CLR_ON_TRST)) begin
         q_d = RST_VAL;
      end else if (cap_en) begin
         q_d = cap_val;
      end else if (shift_en) begin
         q_d = {sdi, q_q[W-1:1]};
      end
   end

   // register only
   always_ff @(posedge ref_clk) begin
      q_q <= q_d;
   end

   assign q   = q_q;
   assign sdo = q_q[0];

endmodule

// file: dv/sclc_tap_model.sv
// test bus controller model: walks tap states and pulses the test clock
`timescale 1ns/1ps
module sclc_tap_model
   import sclc_pkg::*;
(
   input  wire logic ref_clk,   // system clock
   input  wire logic tdo,       // serial data from block
   output sclc_tap_e   tap_state, // tap state
   output sclc_instr_e instr,     // active instruction
   output logic        tck_rise,  // rising test clock pulse
   output logic        tck_fall,  // falling test clock pulse
   output logic        tdi        // serial data to block
);
   // idle values at time zero
   initial begin
      tap_state = TAP_RESET;
      instr     = INS_OTHER;
      tck_rise  = 1'b0;
      tck_fall  = 1'b0;
      tdi       = 1'b0;
   end

   // one test clock: rise acts on the old state, state moves, then fall
   task automatic tck(input sclc_tap_e nxt, input logic d, output logic o);
      @(posedge ref_clk);
      o = tdo;
      tck_rise <= 1'b1;
      tdi      <= d;
      @(posedge ref_clk);
      tck_rise  <= 1'b0;
      tap_state <= nxt;
      @(posedge ref_clk);
      tck_fall <= 1'b1;
      @(posedge ref_clk);
      tck_fall <= 1'b0;
      tdi      <= ~d; // stale data never lingers
   endtask

   // one test clock with throwaway data
   task automatic go(input sclc_tap_e nxt);
      logic o;
      tck(nxt, 1'($urandom), o);
   endtask

   // instruction path, optionally resting in pause
   task automatic load(input sclc_instr_e ins, input bit pause);
      go(TAP_SEL_DR);
      go(TAP_SEL_IR);
      go(TAP_CAP_IR);
      go(TAP_SHIFT_IR);
      go(TAP_EXIT1_IR);
      if (pause) begin
         go(TAP_PAUSE_IR);
         go(TAP_PAUSE_IR);
         go(TAP_EXIT2_IR);
      end
      go(TAP_UPD_IR);
      instr <= ins;
      go(TAP_IDLE);
   endtask

   // data scan, lsb leaves first
   task automatic scan(input sclc_instr_e ins, input int n, input logic [9:0] din, output logic [9:0] dout);
      dout = '0;
      load(ins, 1'b0);
      go(TAP_SEL_DR);
      go(TAP_CAP_DR);
      go(TAP_SHIFT_DR);
      for (int i = 0; i < n; i++) begin
         tck((i == n - 1) ? TAP_EXIT1_DR : TAP_SHIFT_DR, din[i], dout[i]);
      end
      go(TAP_UPD_DR);
      go(TAP_IDLE);
   endtask
endmodule

// file: dv/sclc_top_tb_top.sv
// testbench for the scan linker control and counter block
`timescale 1ns/1ps
module sclc_top_tb_top
   import sclc_pkg::*;
;
   logic              ref_clk = 1'b0;
   logic              nrst, condition_input, perr_n, tdo, tdo_oe_n, co, co_oe_n, dck_oe_n, pause_out;
   logic [IDB_W-1:0]  id_bus;
   logic [NPATH-1:0]  dms_oe_n, ddo_oe_n, ddo_exp;
   logic [SEL_W-1:0]  sel_exp = 8'h00;
   logic [CNT_W-1:0]  count_value, cnt;
   logic [CTL_W-1:0]  scan_control_register, ctl, dout, din;
   sclc_tap_e         tap_state;
   sclc_instr_e       instr;
   logic              tck_rise, tck_fall, tdi;
   logic [1:0]        e;
   int                failures = 0;
   int                comparisons = 0;

   always #2.5 ref_clk = ~ref_clk;

   sclc_tap_model u_tap (.ref_clk(ref_clk), .tdo(tdo), .tap_state(tap_state), .instr(instr),
      .tck_rise(tck_rise), .tck_fall(tck_fall), .tdi(tdi));

   sclc_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .tap_state(tap_state), .instr(instr),
      .tck_rise(tck_rise), .tck_fall(tck_fall), .tdi(tdi), .id_bus(id_bus),
      .condition_input(condition_input), .instruction_parity_error_n(perr_n), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .condition_output(co), .condition_output_oe_n(co_oe_n),
      .downstream_test_clock_oe_n(dck_oe_n), .downstream_mode_select_oe_n(dms_oe_n),
      .downstream_data_out_oe_n(ddo_oe_n), .count_value(count_value),
      .scan_control_register(scan_control_register));

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // expected {oe_n, level} of the condition output
   function automatic logic [1:0] exp_co(input logic [9:0] c, input logic ci, input logic [7:0] n, input logic pe);
      logic act;
      case (c[6:5])
         SRC_IDLE: act = 1'b0;
         SRC_PERR: act = pe & ~c[CTL_PMASK];
         SRC_TERM: act = c[CTL_DOWN] ? (n == CNT_ZERO) : (n == CNT_ONES);
         default:  act = (ci == c[CTL_IPOL]);
      endcase
      act = c[CTL_OPOL] ? act : ~act;
      if (!c[CTL_OEN]) begin
         return 2'b11;
      end
      return c[CTL_TRISTATE] ? {1'b0, act} : {act, act};
   endfunction

   // new control value, old one must come back out
   task automatic set_ctl(input logic [9:0] v);
      u_tap.scan(INS_SCAN_CTL, CTL_W, v, dout);
      check("control readback", dout, ctl);
      ctl = v;
      check("control settings", scan_control_register, ctl);
   endtask

   // counter scan with preload
   task automatic preload(input sclc_instr_e ins, input logic [7:0] v);
      u_tap.scan(ins, CNT_W, 10'(v), dout);
      cnt = v;
      check("count after preload", 10'(count_value), 10'(cnt));
   endtask

   // edges of the condition input into its active level
   task automatic pulse(input int k);
      for (int i = 0; i < k; i++) begin
         @(posedge ref_clk);
         condition_input <= ~ctl[CTL_IPOL];
         repeat (2) @(posedge ref_clk);
         condition_input <= ctl[CTL_IPOL];
         @(posedge ref_clk);
      end
      repeat (2) @(posedge ref_clk);
   endtask

   // shift-time hold of settings, pause-time output capture
   always @(negedge ref_clk) begin
      if (nrst && tap_state == TAP_SHIFT_DR && instr == INS_SCAN_CTL) begin
         check("settings during shift", scan_control_register, ctl);
      end
      if (nrst && tck_rise && tap_state == TAP_SHIFT_DR && instr == INS_SCAN_CTL) begin
         ddo_exp = {4{ctl[CTL_DDIS]}} | ~{sel_exp[7], sel_exp[5], sel_exp[3], sel_exp[1]};
         check("data out enables", 10'(ddo_oe_n), 10'(ddo_exp));
      end
      if (nrst && tck_rise) begin
         check("tdo enable", 10'(tdo_oe_n), 10'(tap_state != TAP_SHIFT_DR));
      end
      if (tck_rise && tap_state == TAP_PAUSE_IR) begin
         pause_out = co;
      end
   end

   // hang guard
   initial begin
      #300000;
      failures++;
      complete_run();
   end

   // main sequence
   initial begin
      logic [9:0] cc [3] = '{10'h000, 10'h200, 10'h300};
      logic [7:0] pv [3] = '{8'hFF, 8'h00, 8'h02};
      logic [7:0] ev [3] = '{8'h00, 8'hFF, 8'h00};
      int         np [3] = '{1, 1, 4};
      logic [7:0] q;
      int         k;
      nrst = 1'b0;
      id_bus = '0;
      condition_input = 1'b1;
      perr_n = 1'b1;
      ctl = CTL_RST;
      void'($urandom(3466));
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("control at reset", scan_control_register, CTL_RST);
      check("output at reset", 10'({co_oe_n, co}), 10'h003);
      check("downstream at reset", 10'({dck_oe_n, dms_oe_n}), 10'h000);
      u_tap.go(TAP_IDLE);
      $display("test reset state done");
      // every source, polarity, direction, random drive and gating bits
      preload(INS_SCAN_CNT, CNT_ONES);
      for (int m = 0; m < 16; m++) begin
         set_ctl({m[3], 1'b0, m[2], m[1:0], 1'b0, 4'($urandom)});
         condition_input <= 1'($urandom);
         repeat (3) @(posedge ref_clk);
         e = exp_co(ctl, condition_input, cnt, 1'b0);
         check("condition output", 10'({co_oe_n, co}), 10'(e));
         check("downstream enables", 10'({dck_oe_n, dms_oe_n}), 10'({5{ctl[CTL_DDIS]}}));
      end
      $display("test condition output done");
      for (int j = 0; j < 3; j++) begin
         set_ctl(cc[j]);
         preload(INS_SCAN_CNT, pv[j]);
         u_tap.load(INS_COUNT, 1'b0);
         pulse(np[j]);
         check("count wrap or latch", 10'(count_value), 10'(ev[j]));
      end
      set_ctl(CTL_RST);
      preload(INS_SCAN_CNT, 8'($urandom));
      pulse(2);
      check("count outside count", 10'(count_value), 10'(cnt));
      u_tap.load(INS_COUNT, 1'b0);
      k = $urandom_range(5, 1);
      pulse(k);
      cnt = cnt + 8'(k);
      check("count up", 10'(count_value), 10'(cnt));
      q = cnt;
      preload(INS_SCAN_CNT, 8'($urandom));
      check("captured live count", dout, 10'(q));
      q = cnt;
      u_tap.load(INS_COUNT, 1'b0);
      pulse(3);
      preload(INS_READ_CNT, 8'($urandom));
      check("captured preload", dout, 10'(q));
      $display("test counter done");
      perr_n <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         set_ctl(10'h02C | (10'(m) << CTL_PMASK));
         u_tap.load(INS_OTHER, 1'b1);
         e = exp_co(ctl, condition_input, cnt, 1'b1);
         check("output in pause", 10'(pause_out), 10'(e[0]));
         check("output after pause", 10'(co), 10'h001);
      end
      perr_n <= 1'b1;
      $display("test parity output done");
      id_bus <= 4'($urandom);
      din = 10'($urandom);
      u_tap.scan(INS_SCAN_IDB, IDB_W, din, dout);
      check("id capture", dout, 10'(id_bus));
      id_bus <= ~id_bus;
      u_tap.scan(INS_READ_IDB, IDB_W, 10'($urandom), dout);
      check("id read", dout, 10'(din[3:0]));
      din = 10'($urandom);
      u_tap.scan(INS_SCAN_SEL, SEL_W, din, dout);
      sel_exp = din[7:0];
      din = 10'($urandom);
      u_tap.scan(INS_SCAN_SEL, SEL_W, din, dout);
      check("select readback", dout, 10'(sel_exp));
      sel_exp = din[7:0];
      $display("test id and select done");
      set_ctl(10'($urandom));
      u_tap.go(TAP_SEL_DR);
      u_tap.go(TAP_SEL_IR);
      u_tap.go(TAP_RESET);
      u_tap.go(TAP_IDLE);
      ctl = CTL_RST;
      sel_exp = 8'h00;
      check("control after test reset", scan_control_register, CTL_RST);
      set_ctl(10'h3FF);
      $display("test test reset done");
      complete_run();
   end
endmodule
